// *** rtl/emi_pkg.sv ***
// Notes on behaviour
// - Every internal interrupt event sets a status flag to one; line sag and zero crossing loss share flag 1.
// - Interrupt request goes low while any set flag other than flag 6 has its enable bit at one.
// - Flag 0 sets on a 0 to 1 change of the energy MSB.
// - Flag 1 sets on a line sag or when zero crossings stop.
// - Flag 2 sets when accumulation over the half cycle count ends.
// - Flag 3 sets whenever a new waveform sample is loaded.
// - Flag 4 follows the zero crossing level and never latches.
// - Flag 5 sets when a temperature result becomes readable.
// - Flag 6 sets at end of any reset and can never request an interrupt.
// - Flag 7 sets when the active energy register overflows.
package emi_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS     = 8'h04;
    localparam logic [7:0] IDX_FLAGS_CLR = 8'h05;
    localparam logic [7:0] IDX_MASK      = 8'h0A;

    // Flag positions
    localparam int BIT_HALF_FULL = 0;
    localparam int BIT_SAG       = 1;
    localparam int BIT_CYC_DONE  = 2;
    localparam int BIT_WAVE      = 3;
    localparam int BIT_ZX        = 4;
    localparam int BIT_TEMP      = 5;
    localparam int BIT_RST_DONE  = 6;
    localparam int BIT_OVF       = 7;

    // Reset values; reset-done flag is up as the reset ends
    localparam logic [7:0] FLAGS_RST = 8'h40;
    localparam logic [7:0] MASK_RST  = 8'h00;
    // Flags allowed onto the request line (reset-done excluded)
    localparam logic [7:0] IRQ_ABLE  = 8'hBF;
    // Flags that latch and are cleared by a clearing read
    localparam logic [7:0] LATCHED   = 8'hEF;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Internal event sources, all on clk
    typedef struct packed {
        logic energy_msb;   // Level: MSB of accumulated energy
        logic energy_ovf;   // Pulse: energy register overflow
        logic sag;          // Pulse: line sag detected
        logic zx_lost;      // Pulse: zero crossings stopped
        logic cycle_done;   // Pulse: line cycle accumulation finished
        logic wave_sample;  // Pulse: new waveform sample loaded
        logic zx_level;     // Level: zero crossing logic output
        logic temp_done;    // Pulse: temperature result ready
        logic sw_reset;     // Level: software reset in progress
    } emi_evt_t;

endpackage : emi_pkg

// *** rtl/emi_edge.sv ***
`timescale 1ns/1ps
// Edge finder for level sources on clk
module emi_edge #(
    parameter int W = 2
) (
    input  wire logic         clk,   // System clock
    input  wire logic         rstn,  // Async reset, active low
    input  wire logic [W-1:0] lvl,   // Levels to watch
    output logic      [W-1:0] rise,  // One-cycle pulse on 0 to 1
    output logic      [W-1:0] fall   // One-cycle pulse on 1 to 0
);
    logic [W-1:0] prev_q;

    // Previous level; zero after reset so a level high at release counts as a rise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= '0;
        end else begin
            prev_q <= lvl;
        end
    end

    // Per-bit edges
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_edge
            assign rise[i] = lvl[i] & ~prev_q[i];
            assign fall[i] = ~lvl[i] & prev_q[i];
        end
    endgenerate

endmodule : emi_edge

// *** rtl/emi_top.sv ***
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Interrupt flags, enables and request line behind an AXI4-Lite slave
module emi_top #(
    parameter int AW = 8
) (
    input  wire logic              clk,      // System clock, 125 MHz
    input  wire logic              rstn,     // Async reset, active low
    input  wire emi_pkg::emi_evt_t evt,      // Internal event sources
    output logic                   irq_n,    // Interrupt request, active low
    input  wire logic [AW-1:0]     awaddr,   // Write address
    input  wire logic              awvalid,  // Write address valid
    output logic                   awready,  // Write address ready
    input  wire logic [31:0]       wdata,    // Write data
    input  wire logic [3:0]        wstrb,    // Write strobes
    input  wire logic              wvalid,   // Write data valid
    output logic                   wready,   // Write data ready
    output logic [1:0]             bresp,    // Write response
    output logic                   bvalid,   // Write response valid
    input  wire logic              bready,   // Write response ready
    input  wire logic [AW-1:0]     araddr,   // Read address
    input  wire logic              arvalid,  // Read address valid
    output logic                   arready,  // Read address ready
    output logic [31:0]            rdata,    // Read data
    output logic [1:0]             rresp,    // Read response
    output logic                   rvalid,   // Read data valid
    input  wire logic              rready    // Read data ready
);
    logic [7:0]    flags_q;
    logic [7:0]    flags_d;
    logic [7:0]    mask_q;
    logic [7:0]    set_v;
    logic [1:0]    rise_v;
    logic [1:0]    fall_v;
    logic          aw_have_q;
    logic          w_have_q;
    logic [AW-1:0] awaddr_q;
    logic [31:0]   wdata_q;
    logic [3:0]    wstrb_q;
    logic          ar_hs;
    logic          clr_rd;

    // Flag positions under short local names
    localparam int BIT_HALF_FULL = emi_pkg::BIT_HALF_FULL;
    localparam int BIT_SAG       = emi_pkg::BIT_SAG;
    localparam int BIT_CYC_DONE  = emi_pkg::BIT_CYC_DONE;
    localparam int BIT_WAVE      = emi_pkg::BIT_WAVE;
    localparam int BIT_ZX        = emi_pkg::BIT_ZX;
    localparam int BIT_TEMP      = emi_pkg::BIT_TEMP;
    localparam int BIT_RST_DONE  = emi_pkg::BIT_RST_DONE;
    localparam int BIT_OVF       = emi_pkg::BIT_OVF;

    // Register index from a byte address
    function automatic logic [7:0] reg_idx(input logic [AW-1:0] a);
        reg_idx = 8'(a >> 2);
    endfunction : reg_idx

    // Level sources: energy MSB and software reset
    emi_edge #(
        .W(2)
    ) u_edge (
        .clk (clk),
        .rstn(rstn),
        .lvl ({evt.sw_reset, evt.energy_msb}),
        .rise(rise_v),
        .fall(fall_v)
    );

    // Event set vector; sag and zero crossing loss share flag 1
    always_comb begin
        set_v                = 8'h00;
        set_v[BIT_HALF_FULL] = rise_v[0];
        set_v[BIT_SAG]       = evt.sag | evt.zx_lost;
        set_v[BIT_CYC_DONE]  = evt.cycle_done;
        set_v[BIT_WAVE]      = evt.wave_sample;
        set_v[BIT_TEMP]      = evt.temp_done;
        set_v[BIT_RST_DONE]  = fall_v[1];
        set_v[BIT_OVF]       = evt.energy_ovf;
    end

    assign ar_hs  = arvalid & arready;
    assign clr_rd = ar_hs & (reg_idx(araddr) == emi_pkg::IDX_FLAGS_CLR);

    // Next flags: set wins over a clearing read in the same cycle so no event is lost
    always_comb begin
        flags_d = flags_q;
        if (clr_rd) begin
            flags_d = flags_q & ~emi_pkg::LATCHED;
        end
        flags_d         = flags_d | set_v;
        flags_d[BIT_ZX] = evt.zx_level;
    end

    // Status flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= emi_pkg::FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Request line from the next state so it tracks flags_q and mask_q exactly
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~|(flags_d & mask_d() & emi_pkg::IRQ_ABLE);
        end
    end

    // Write channel capture; each channel taken independently
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= awaddr;
            end else if (bvalid && bready) begin
                aw_have_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end else if (bvalid && bready) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // Next mask value, applied when both halves of a mask write with the lane 0 strobe on are held
    function automatic logic [7:0] mask_d();
        mask_d = mask_q;
        if (aw_have_q && w_have_q && !bvalid && wstrb_q[0]
            && reg_idx(awaddr_q) == emi_pkg::IDX_MASK) begin
            mask_d = wdata_q[7:0];
        end
    endfunction : mask_d

    // Enable register, same layout as the flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= emi_pkg::MASK_RST;
        end else begin
            mask_q <= mask_d();
        end
    end

    // Ready flags; low while a write is held or its response pending
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
        end else begin
            awready <= ~aw_have_q & ~(awvalid & awready) & ~bvalid;
            wready  <= ~w_have_q & ~(wvalid & wready) & ~bvalid;
        end
    end

    // Write response; read-only targets answer SLVERR, holes DECERR
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bvalid <= 1'b0;
            bresp  <= emi_pkg::RESP_OKAY;
        end else if (bvalid) begin
            bvalid <= ~bready;
        end else if (aw_have_q && w_have_q) begin
            bvalid <= 1'b1;
            case (reg_idx(awaddr_q))
                emi_pkg::IDX_MASK:      bresp <= emi_pkg::RESP_OKAY;
                emi_pkg::IDX_FLAGS,
                emi_pkg::IDX_FLAGS_CLR: bresp <= emi_pkg::RESP_SLVERR;
                default:                bresp <= emi_pkg::RESP_DECERR;
            endcase
        end
    end

    // Read channel: one read at a time, answer one cycle after the address
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= emi_pkg::RESP_OKAY;
        end else if (rvalid) begin
            rvalid  <= ~rready;
            arready <= rready;
        end else if (ar_hs) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= 32'h0000_0000;
            rresp   <= emi_pkg::RESP_OKAY;
            case (reg_idx(araddr))
                emi_pkg::IDX_FLAGS:     rdata[7:0] <= flags_q;
                emi_pkg::IDX_FLAGS_CLR: rdata[7:0] <= flags_q;
                emi_pkg::IDX_MASK:      rdata[7:0] <= mask_q;
                default:                rresp      <= emi_pkg::RESP_DECERR;
            endcase
        end else begin
            arready <= 1'b1;
        end
    end

    // Checks on flag setting, clearing and the request line
    ovf_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        evt.energy_ovf |=> flags_q[BIT_OVF])
        else $error("overflow flag not set");
    sag_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        (evt.sag || evt.zx_lost) |=> flags_q[BIT_SAG])
        else $error("sag flag not set");
    cycle_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        evt.cycle_done |=> flags_q[BIT_CYC_DONE])
        else $error("cycle flag not set");
    wave_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        evt.wave_sample |=> flags_q[BIT_WAVE])
        else $error("sample flag not set");
    temp_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        evt.temp_done |=> flags_q[BIT_TEMP])
        else $error("temperature flag not set");
    half_full_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(evt.energy_msb) |=> flags_q[BIT_HALF_FULL])
        else $error("half full flag not set");
    zx_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        ##1 flags_q[BIT_ZX] == $past(evt.zx_level))
        else $error("zero crossing flag does not follow level");
    reset_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(evt.sw_reset) |=> flags_q[BIT_RST_DONE])
        else $error("reset done flag not set");
    rst_no_irq_a: assert property (@(posedge clk) disable iff (!rstn)
        ((flags_q & mask_q) == (8'h01 << BIT_RST_DONE)) |-> irq_n)
        else $error("reset done flag drove the request line");
    set_wins_a: assert property (@(posedge clk) disable iff (!rstn)
        clr_rd |=> ((flags_q & $past(set_v)) == $past(set_v)))
        else $error("event lost during clearing read");
    irq_level_a: assert property (@(posedge clk) disable iff (!rstn)
        ##1 irq_n == !(|(flags_q & mask_q & emi_pkg::IRQ_ABLE)))
        else $error("request line disagrees with flags");
    clear_read_a: assert property (@(posedge clk) disable iff (!rstn)
        (clr_rd && set_v == 8'h00) |=> ((flags_q & emi_pkg::LATCHED) == 8'h00)
        && rvalid && rdata[7:0] == $past(flags_q))
        else $error("clearing read did not clear");
    plain_read_a: assert property (@(posedge clk) disable iff (!rstn)
        (ar_hs && reg_idx(araddr) == emi_pkg::IDX_FLAGS) |=>
        (($past(flags_q) & ~flags_q & emi_pkg::LATCHED) == 8'h00))
        else $error("plain status read cleared a flag");

endmodule : emi_top

// *** test/emi_host.sv ***
`timescale 1ns/1ps
// Host model: AXI4-Lite master with a flag service task; irq_n is left unused
module emi_host (
    input  wire logic        clk,      // System clock
    input  wire logic        irq_n,    // Request, active low
    output logic [7:0]       awaddr,   // Write address
    output logic             awvalid,  // Write address valid
    input  wire logic        awready,  // Write address ready
    output logic [31:0]      wdata,    // Write data
    output logic [3:0]       wstrb,    // Write strobes
    output logic             wvalid,   // Write data valid
    input  wire logic        wready,   // Write data ready
    input  wire logic [1:0]  bresp,    // Write response
    input  wire logic        bvalid,   // Write response valid
    output logic             bready,   // Write response ready
    output logic [7:0]       araddr,   // Read address
    output logic             arvalid,  // Read address valid
    input  wire logic        arready,  // Read address ready
    input  wire logic [31:0] rdata,    // Read data
    input  wire logic [1:0]  rresp,    // Read response
    input  wire logic        rvalid,   // Read data valid
    output logic             rready    // Read data ready
);
    int         slow = 0;     // Cycles of delay before taking an answer
    logic [3:0] strb = 4'hF;  // Byte strobes for the next write

    // Idle bus at time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, wstrb, araddr} = '0;
    end

    // Write; released payload is inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit pa;
        bit pw;
        pa = 1;
        pw = 1;
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && awready) begin
                pa = 0;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (pw && wready) begin
                pw = 0;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        repeat (slow) @(posedge clk);
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    // Read one word
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        repeat (slow) @(posedge clk);
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    // Service: learn the cause first, then clear it
    task automatic svc(output logic [31:0] f);
        logic [31:0] d;
        logic [1:0]  r;
        rd({emi_pkg::IDX_FLAGS[5:0], 2'b00}, f, r);
        rd({emi_pkg::IDX_FLAGS_CLR[5:0], 2'b00}, d, r);
    endtask : svc
endmodule : emi_host

// *** test/emi_top_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the interrupt flag block
module emi_top_tb;
    localparam logic [7:0] A_FLG = {emi_pkg::IDX_FLAGS[5:0], 2'b00};
    localparam logic [7:0] A_CLR = {emi_pkg::IDX_FLAGS_CLR[5:0], 2'b00};
    localparam logic [7:0] A_MSK = {emi_pkg::IDX_MASK[5:0], 2'b00};
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    emi_pkg::emi_evt_t evt = '0;
    logic              irq_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [7:0]        awaddr, araddr, m;
    logic [31:0]       wdata, rdata, d;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, r;
    int                errors = 0;
    int                checks_done = 0;
    // Event slot in evt and the flag it raises
    int                evs[8] = '{8, 6, 5, 4, 3, 1, 0, 7};
    int                fbs[8] = '{0, 1, 1, 2, 3, 5, 6, 7};

    always #4 clk = ~clk;

    emi_top #(.AW(8)) uut (.clk(clk), .rstn(rstn), .evt(evt), .irq_n(irq_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    emi_host u_host (.clk(clk), .irq_n(irq_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // Request level expected for given flags and mask
    function automatic logic exp_irq(logic [7:0] f, logic [7:0] k);
        return ~|(f & k & emi_pkg::IRQ_ABLE);
    endfunction : exp_irq

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle event, then time for edge finders and the request to settle
    task automatic pulse(input int k);
        evt[k] <= 1'b1;
        @(posedge clk);
        evt[k] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic test_done;
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // Whole run is a few hundred cycles; this bound of 40000 cycles is generous
    initial begin
        #(40000 * 8);
        errors++;
        test_done();
    end

    initial begin
        void'($urandom(48724));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        u_host.rd(A_FLG, d, r);
        chk(d, 32'h0000_0040);
        chk(irq_n, 1'b1);
        m = 8'($urandom());
        u_host.wr(A_MSK, {24'h00_0000, m}, r);
        chk(r, emi_pkg::RESP_OKAY);
        u_host.rd(A_MSK, d, r);
        chk(d, {24'h00_0000, m});
        // Lane 0 strobe off: the write is answered but leaves the mask alone
        u_host.strb = 4'hE;
        u_host.wr(A_MSK, {24'h00_0000, ~m}, r);
        chk(r, emi_pkg::RESP_OKAY);
        u_host.rd(A_MSK, d, r);
        chk(d, {24'h00_0000, m});
        u_host.strb = 4'hF;
        u_host.wr(A_FLG, 32'h0000_00FF, r);
        chk(r, emi_pkg::RESP_SLVERR);
        u_host.wr(8'h3C, 32'h0000_00FF, r);
        chk(r, emi_pkg::RESP_DECERR);
        u_host.rd(8'h3C, d, r);
        chk(d, 32'h0000_0000);
        chk(r, emi_pkg::RESP_DECERR);
        $display("test regs done");
        // Each latching source, enable bit off with prompt host, then on with slow host
        for (int c = 0; c < 8; c++) begin
            for (int p = 0; p < 2; p++) begin
                u_host.slow = p;
                m = 8'($urandom());
                m[fbs[c]] = p[0];
                u_host.wr(A_MSK, {24'h00_0000, m}, r);
                u_host.rd(A_CLR, d, r);
                pulse(evs[c]);
                chk(irq_n, exp_irq(8'(1 << fbs[c]), m));
                u_host.svc(d);
                chk(d, 32'(1 << fbs[c]));
                u_host.rd(A_FLG, d, r);
                chk(d, 32'h0000_0000);
                chk(irq_n, 1'b1);
            end
        end
        $display("test events done");
        // Zero-crossing flag is a live copy that clearing reads leave alone
        u_host.wr(A_MSK, 32'h0000_0010, r);
        evt.zx_level <= 1'b1;
        repeat (4) @(posedge clk);
        chk(irq_n, 1'b0);
        u_host.rd(A_CLR, d, r);
        chk(d, 32'h0000_0010);
        u_host.rd(A_FLG, d, r);
        chk(d, 32'h0000_0010);
        evt.zx_level <= 1'b0;
        repeat (4) @(posedge clk);
        chk(irq_n, 1'b1);
        $display("test zx done");
        // Reset again in mid-run
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        u_host.rd(A_FLG, d, r);
        chk(d, 32'h0000_0040);
        u_host.rd(A_MSK, d, r);
        chk(d, 32'h0000_0000);
        $display("test reset done");
        test_done();
    end
endmodule : emi_top_tb
